// [hdl/wbh_supervisor.sv]
/*
 * Supervisory timer and low-supply hold sequencer for a 4-bit controller core.
 * Assumes the core advances only on core_clk_en and pulses instr_done on the
 * enable that completes an instruction; all inputs are synchronous to clk.
 */
// Contract
// RL1: Timer resets chip at one second terminal.
// RL2: Timer runs from reset, never disabled.
// RL3: Hold while supply low, resume when restored.
// RL4: Hold begins only at instruction boundary.
// RL5: Ring oscillator keeps running during hold.
// RL6: Core state frozen in hold, resumes after.
// RL7: Counting uses 2 MHz system clock ticks.
// RL8: External reset pin high resets device.
// RL9: Clear strobe or chip reset zeroes timer.
`timescale 1ns/1ps

module wbh_supervisor #(
    parameter int unsigned SUP_TICKS = wbh_pkg::SUP_TICKS
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Core and supply detector
    input  wire wbh_pkg::wbh_in_t ctl_in,
    // Chip-level controls
    output wbh_pkg::wbh_out_t     ctl_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    wbh_pkg::wbh_reg_t st_r;
    wbh_pkg::wbh_reg_t st_nxt;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam logic [wbh_pkg::SUP_CNT_W-1:0] TERM =
        wbh_pkg::SUP_CNT_W'(SUP_TICKS - 1);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Core may advance in every state but hold
    function automatic logic run_state(
        input wbh_pkg::wbh_state_t s
    );
        run_state = (s != wbh_pkg::WBH_HOLD);
    endfunction

    // Divider sum, one bit wider than the accumulator
    function automatic logic [10:0] div_sum(
        input logic [9:0] acc
    );
        div_sum = {1'b0, acc} + {1'b0, wbh_pkg::DIV_STEP};
    endfunction

    // Divider wraps once per system tick
    function automatic logic div_wrap(
        input logic [9:0] acc
    );
        div_wrap = (div_sum(acc) >= {1'b0, wbh_pkg::DIV_MOD});
    endfunction

    // Accumulator after one clk
    function automatic logic [9:0] div_next(
        input logic [9:0] acc
    );
        logic [10:0] sum;
        sum = div_sum(acc);
        if (div_wrap(acc)) begin
            sum = sum - {1'b0, wbh_pkg::DIV_MOD};
        end
        div_next = sum[9:0];
    endfunction

    // Reset stretch counts down on system ticks
    function automatic logic [2:0] stretch_next(
        input logic [2:0] s,
        input logic       tick
    );
        stretch_next = s;
        if (tick && (s != 3'h0)) begin
            stretch_next = s - 3'h1;
        end
    endfunction

    // Chip held in reset by the pin or by a stretched timer reset
    function automatic logic reset_cause(
        input logic       pin,
        input logic [2:0] stretch
    );
        reset_cause = pin || (stretch != 3'h0);
    endfunction

    // Timer has reached its terminal count
    function automatic logic at_term(
        input logic [wbh_pkg::SUP_CNT_W-1:0] cnt
    );
        at_term = (cnt == TERM);
    endfunction

    // Timer step: clear, count, or fire at the terminal count
    function automatic logic [wbh_pkg::SUP_CNT_W-1:0] cnt_next(
        input  logic [wbh_pkg::SUP_CNT_W-1:0] cnt,
        input  logic                          clr,
        input  logic                          tick,
        output logic                          fire
    );
        fire     = 1'b0;
        cnt_next = cnt;
        if (clr) begin
            cnt_next = wbh_pkg::CNT_RST;  // RL9
        end else if (tick) begin  // RL2
            if (at_term(cnt)) begin
                fire     = 1'b1;  // RL1
                cnt_next = wbh_pkg::CNT_RST;
            end else begin
                cnt_next = cnt + 1'b1;  // RL7
            end
        end
    endfunction

    // Hold sequencer transition outside reset
    function automatic wbh_pkg::wbh_state_t fsm_next(
        input wbh_pkg::wbh_state_t s,
        input logic                low,
        input logic                done
    );
        fsm_next = s;
        case (s)
            wbh_pkg::WBH_RUN: begin
                if (low) begin  // RL3
                    fsm_next = done ? wbh_pkg::WBH_HOLD : wbh_pkg::WBH_PEND;  // RL4
                end
            end
            wbh_pkg::WBH_PEND: begin
                if (!low) begin
                    fsm_next = wbh_pkg::WBH_RUN;
                end else if (done) begin
                    fsm_next = wbh_pkg::WBH_HOLD;  // RL4
                end
            end
            wbh_pkg::WBH_HOLD: begin
                if (!low) begin
                    fsm_next = wbh_pkg::WBH_RUN;  // RL3
                end
            end
            default: begin
                fsm_next = wbh_pkg::WBH_RUN;
            end
        endcase
    endfunction

    // Output word for the next state
    function automatic wbh_pkg::wbh_out_t out_next(
        input logic                tick,
        input wbh_pkg::wbh_state_t fsm,
        input logic                rst
    );
        out_next.sys_tick            = tick;
        out_next.ring_oscillator_run = 1'b1;  // RL5
        out_next.chip_reset          = rst;  // RL1
        out_next.hold                = (fsm == wbh_pkg::WBH_HOLD);
        out_next.core_clk_en         = tick && run_state(fsm) && !rst;  // RL6
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic tick;
        logic fire;
        logic in_rst;
        tick   = 1'b0;
        fire   = 1'b0;
        in_rst = 1'b0;
        st_nxt = st_r;

        // Fractional divider gives an average 2 MHz enable
        tick       = div_wrap(st_r.acc);  // RL7
        st_nxt.acc = div_next(st_r.acc);

        // Supervisory timer, always counting
        st_nxt.stretch = stretch_next(st_r.stretch, tick);
        in_rst         = reset_cause(ctl_in.chip_reset_pin, st_r.stretch);  // RL8
        st_nxt.cnt     = cnt_next(st_r.cnt, in_rst || ctl_in.sup_clear, tick, fire);
        if (fire) begin
            st_nxt.stretch = wbh_pkg::RST_STRETCH;  // RL1
        end

        // Hold sequencer
        if (in_rst || fire) begin
            st_nxt.fsm = wbh_pkg::WBH_RUN;
        end else begin
            st_nxt.fsm = fsm_next(st_r.fsm, ctl_in.low_supply, ctl_in.instr_done);
        end

        // Registered outputs
        st_nxt.out = out_next(tick, st_nxt.fsm, in_rst || fire);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.acc     <= wbh_pkg::ACC_RST;
            st_r.cnt     <= wbh_pkg::CNT_RST;
            st_r.stretch <= 3'h0;
            st_r.fsm     <= wbh_pkg::WBH_RUN;
            st_r.out     <= '{chip_reset: 1'b1, core_clk_en: 1'b0, hold: 1'b0,
                              ring_oscillator_run: 1'b1, sys_tick: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ctl_out = st_r.out;

endmodule

// [inc/wbh_pkg.sv]
/*
 * Constants and carrier types for the supervisory timer and low-supply hold block.
 * Assumes a 125 MHz clk; the 2 MHz system rate is made by a fractional enable divider.
 */
package wbh_pkg;

    // ------------------------------------------------------------
    // Clock rates and divider
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned SYS_CLK_HZ    = 2_000_000;
    localparam int unsigned DIV_GCD       = 125_000;
    localparam logic [9:0]  DIV_STEP      = 10'(SYS_CLK_HZ / DIV_GCD);
    localparam logic [9:0]  DIV_MOD       = 10'(CLK_HZ / DIV_GCD);

    // ------------------------------------------------------------
    // Supervisory timer timing
    // ------------------------------------------------------------
    localparam int unsigned SUP_PERIOD_MS = 1000;
    localparam int unsigned SUP_TICKS     = SYS_CLK_HZ / 1000 * SUP_PERIOD_MS;
    localparam int unsigned SUP_CNT_W     = 21;
    localparam logic [2:0]  RST_STRETCH   = 3'h4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0]           ACC_RST = 10'h000;
    localparam logic [SUP_CNT_W-1:0] CNT_RST = 21'h000000;

    // ------------------------------------------------------------
    // Hold sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WBH_RUN  = 3'h1,
        WBH_PEND = 3'h2,
        WBH_HOLD = 3'h4
    } wbh_state_t;

    // ------------------------------------------------------------
    // Controller-side inputs and outputs
    // ------------------------------------------------------------
    typedef struct packed {
        logic sup_clear;
        logic instr_done;
        logic low_supply;
        logic chip_reset_pin;
    } wbh_in_t;

    typedef struct packed {
        logic chip_reset;
        logic core_clk_en;
        logic hold;
        logic ring_oscillator_run;
        logic sys_tick;
    } wbh_out_t;

    // ------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0]           acc;
        logic [SUP_CNT_W-1:0] cnt;
        logic [2:0]           stretch;
        wbh_state_t           fsm;
        wbh_out_t             out;
    } wbh_reg_t;

endpackage

// [dv/wbh_core_model.sv]
/* Behavioural 4-bit core: one instruction per 8 enables.
   Assumes core_clk_en and chip_reset come from wbh_supervisor. */
`timescale 1ns/1ps
module wbh_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // From supervisor
    input  wire logic        core_clk_en,
    input  wire logic        chip_reset,
    // To supervisor and bench
    output logic             instr_done,
    output logic [15:0]      pc
);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) pc <= 16'h0000;
        else if (chip_reset) pc <= 16'h0000;
        else if (core_clk_en) pc <= pc + 16'h0001;
    assign instr_done = core_clk_en && (pc[2:0] == 3'h7);
endmodule

// [dv/wbh_supervisor_properties.sv]
/* Port checker for wbh_supervisor.
   Bound to every instance; sees only its ports. */
`timescale 1ns/1ps
module wbh_supervisor_properties #(parameter int unsigned SUP_TICKS = 20) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire wbh_pkg::wbh_in_t  ctl_in,
    input wire wbh_pkg::wbh_out_t ctl_out
);
    logic [21:0] n_r;
    logic        src_r;
    // Ticks seen since the last clear
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) begin
            n_r   <= 22'h000000;
            src_r <= 1'b0;
        end else if (ctl_in.chip_reset_pin || ctl_out.chip_reset) begin
            n_r   <= 22'h000000;
            src_r <= 1'b0;
        end else if (ctl_in.sup_clear) begin
            n_r   <= 22'h000000;
            src_r <= 1'b1;
        end else if (ctl_out.sys_tick) n_r <= n_r + 22'h000001;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_osc_runs:  assert property (ctl_out.ring_oscillator_run) else $error("osc stopped");
    a_hold_frz:  assert property ((ctl_out.hold || ctl_out.chip_reset) |-> !ctl_out.core_clk_en)
        else $error("core enabled in hold");
    a_en_tick:   assert property (ctl_out.core_clk_en |-> ctl_out.sys_tick) else $error("en off tick");
    a_tick_pace: assert property (ctl_out.sys_tick |=> !ctl_out.sys_tick[*8] ##[1:60] ctl_out.sys_tick)
        else $error("tick rate wrong");
    a_hold_low:  assert property (ctl_out.hold |-> $past(ctl_in.low_supply)) else $error("hold w/o low");
    a_hold_exit: assert property (ctl_out.hold && !ctl_in.low_supply |=> !ctl_out.hold)
        else $error("hold not left");
    a_hold_edge: assert property ($rose(ctl_out.hold) |-> $past(ctl_in.instr_done))
        else $error("hold mid instr");
    a_pin_reset: assert property (ctl_in.chip_reset_pin |=> ctl_out.chip_reset) else $error("pin ignored");
    a_timer_max: assert property (n_r <= SUP_TICKS) else $error("timer overdue");
    a_timer_min: assert property ($rose(ctl_out.chip_reset) && src_r |-> n_r >= SUP_TICKS - 1)
        else $error("timer early");
endmodule
bind wbh_supervisor wbh_supervisor_properties #(.SUP_TICKS(SUP_TICKS)) u_props (
    .clk(clk), .rst_n(rst_n), .ctl_in(ctl_in), .ctl_out(ctl_out));

// [dv/testbench.sv]
/* Self-checking bench for wbh_supervisor.
   Inputs change at falling clk; core model gives instr_done. */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, low = 1'b0, pin = 1'b0, done;
    logic [15:0] pc, pc0;
    int err_count = 0, n_compared = 0, cyc = 0, rc = 0, n;
    wbh_pkg::wbh_out_t q;
    always #4 clk = ~clk;
    wbh_supervisor #(.SUP_TICKS(20)) DUT (.clk(clk), .rst_n(rst_n),
        .ctl_in(wbh_pkg::wbh_in_t'({clr, done, low, pin})), .ctl_out(q));
    wbh_core_model u_core (.clk(clk), .rst_n(rst_n), .core_clk_en(q.core_clk_en),
        .chip_reset(q.chip_reset), .instr_done(done), .pc(pc));
    always @(posedge clk) begin
        cyc++;
        rc += int'(q.chip_reset === 1'b1);
        if (cyc == 12000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_out(input int sel, input logic v, input int lim, output int k);
        k = 0;
        while ((sel ? q.hold : q.chip_reset) !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic pulse_clear;
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
    endtask
    task automatic t_watchdog;
        wait_out(0, 1'b1, 2000, n);
        chk("fire time", 16'h1, 16'(n > 1150 && n < 1400));
        wait_out(0, 1'b0, 400, n);
        chk("stretch", 16'h1, 16'(n > 180 && n < 400));
    endtask
    task automatic t_clear;
        n = rc;
        repeat (6) begin
            pulse_clear();
            repeat (600) @(negedge clk);
        end
        chk("no reset", 16'h0, 16'(rc - n));
    endtask
    task automatic t_hold;
        pulse_clear();
        low = 1'b1;
        wait_out(1, 1'b1, 600, n);
        chk("hold in", 16'h1, 16'(q.hold));
        chk("boundary", 16'h0, 16'(pc[2:0]));
        pc0 = pc;
        repeat (400) @(negedge clk);
        chk("frozen", pc0, pc);
        chk("osc", 16'h1, 16'(q.ring_oscillator_run));
        low = 1'b0;
        repeat (2) @(negedge clk);
        chk("hold out", 16'h0, 16'(q.hold));
        repeat (150) @(negedge clk);
        chk("resumed", 16'h1, 16'(pc > pc0));
    endtask
    task automatic t_pin;
        pulse_clear();
        repeat (1000) @(negedge clk);
        pin = 1'b1;
        repeat (3) @(negedge clk);
        chk("pin reset", 16'h1, 16'(q.chip_reset));
        pin = 1'b0;
        wait_out(0, 1'b0, 10, n);
        n = rc;
        repeat (1000) @(negedge clk);
        chk("count zeroed", 16'h0, 16'(rc - n));
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_watchdog();
        t_clear();
        t_hold();
        t_pin();
        end_of_test();
    end
endmodule
